// ### src/flash_spm_regs.svh
`ifndef FLASH_SPM_REGS_SVH
`define FLASH_SPM_REGS_SVH

// control byte bit positions
`define CTL_ENABLE_BIT    0
`define CTL_ERASE_BIT     1
`define CTL_WRITE_BIT     2
`define CTL_REENABLE_BIT  4
// variant 0: 4096 words, 32-word pages; variant 1: 8192 words, 64-word pages
`define V0_PAGE_HI        12
`define V0_PAGE_LO        6
`define V0_WORD_HI        5
`define V1_PAGE_HI        13
`define V1_PAGE_LO        7
`define V1_WORD_HI        6
`define WORD_LO           1
`define V0_NO_READ_WHILE_WRITE_REGION_START     13'h0c00
`define V1_NO_READ_WHILE_WRITE_REGION_START     13'h1c00
`define V0_BOOT_11        13'h0f80
`define V0_BOOT_10        13'h0f00
`define V0_BOOT_01        13'h0e00
`define V0_BOOT_00        13'h0c00
`define V1_BOOT_11        13'h1f80
`define V1_BOOT_10        13'h1f00
`define V1_BOOT_01        13'h1e00
`define V1_BOOT_00        13'h1c00
// store instruction must follow the control write within this many cycles
`define ARM_WINDOW        3'h4
// programming time, microseconds, and core clock in MHz
`define PROG_MIN_US       3700
`define PROG_MAX_US       4500
`define CLK_MHZ           250
`define PROG_CYCLES       (`PROG_MIN_US * `CLK_MHZ)
`define BUF_WORDS         64

`endif

// ### src/flash_spm_pkg.sv
package flash_spm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY  = 2'b10
  } spm_state_t;

  typedef enum logic [1:0] {
    OP_FILL   = 2'b00,
    OP_ERASE  = 2'b01,
    OP_WRITE  = 2'b10,
    OP_REEN   = 2'b11
  } spm_op_t;

  // request to the flash array
  typedef struct packed {
    logic        erase;
    logic        write;
    logic [6:0]  page;
  } flash_req_t;
endpackage

// ### src/flash_self_program_control.sv
// Overview of operation
// [R01] 4096-word part: boot size codes 11..00 give boot start f80,f00,e00,c00.
// [R02] 8192-word part: boot size codes 11..00 give boot start 1f80..1c00.
// [R03] 4096-word part: readable region below c00, protected region c00-fff.
// [R04] 8192-word part: readable region below 1c00, protected region 1c00-1fff.
// [R05] 4096-word part: page from pointer 12:6, word from pointer 5:1.
// [R06] 8192-word part: page from pointer 13:7, word from pointer 6:1.
// [R07] page field picks erase/write page; word field only picks buffer word.
// [R08] software keeps word field zero when issuing a page write.
// [R09] pointer bit 0 zero for commands; it selects byte on program reads.
// [R10] 4096-word part ignores pointer bits 15:13.
// [R11] 8192-word part ignores pointer bits 15:14.
// [R12] during erase/write only protected-region fetches are allowed.
// [R13] software polls enable bit low before a new command.
// [R14] software waits for eeprom write to finish before a command.
// [R15] busy flag stays set until readable section is re-enabled.
// [R16] re-enable command clears busy so readable region reads again; code reopens readable-region fetches when ST_BUSY ends, not on re-enable.
// [R17] erase plus enable erases the selected page.
// [R18] enable alone loads r1:r0 into buffer at word position.
// [R19] write plus enable programs whole buffer into the selected page.
// [R20] software relocates vectors or masks interrupts while programming.
// [R21] erase/write timed between 3.7 and 4.5 ms.
// [R22] store instruction must follow control write in a short window.
// [R23] commands during a running operation are ignored, enable stays set.
`include "flash_spm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_control
  import flash_spm_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  // configuration straps
  input  wire logic        large_variant_in,
  input  wire logic        boot_size_hi_in,
  input  wire logic        boot_size_lo_in,
  // core side
  input  wire logic        ctl_write_in,
  input  wire logic [7:0]  ctl_data_in,
  input  wire logic        spm_exec_in,
  input  wire logic [15:0] z_pointer_in,
  input  wire logic [15:0] r1r0_in,
  input  wire logic [12:0] fetch_addr_in,
  input  wire logic        eeprom_write_pending_in,
  // status
  output logic [7:0]       ctl_read_out,
  output logic             readable_section_busy_out,
  output logic             fetch_allowed_out,
  output logic [12:0]      boot_start_out,
  output logic [12:0]      app_end_out,
  output logic             byte_select_out,
  // flash array side
  output flash_req_t       flash_req_out,
  output logic             flash_start_out,
  output logic [15:0]      buf_word_out,
  input  wire logic [5:0]  buf_rd_index_in
);

  localparam logic [23:0] PROG_CYC = 24'(`PROG_CYCLES);

  spm_state_t  state_q;
  spm_op_t     op_q;
  logic [7:0]  ctl_q;
  logic [2:0]  win_q;
  logic [23:0] timer_q;
  logic        busy_q;
  logic [15:0] page_buf [`BUF_WORDS];
  logic [6:0]  page_sel;
  logic [5:0]  word_sel;
  logic [12:0] no_read_while_write_region_start;
  logic [12:0] boot_start_d;

  // pointer split; upper pointer bits never reach the decode
  always_comb begin
    if (large_variant_in) begin
      page_sel = z_pointer_in[`V1_PAGE_HI:`V1_PAGE_LO];                 // [R06] [R11]
      word_sel = z_pointer_in[`V1_WORD_HI:`WORD_LO];                    // [R06]
      no_read_while_write_region_start = `V1_NO_READ_WHILE_WRITE_REGION_START;                                      // [R04]
    end else begin
      page_sel = z_pointer_in[`V0_PAGE_HI:`V0_PAGE_LO];                 // [R05] [R10]
      word_sel = {1'b0, z_pointer_in[`V0_WORD_HI:`WORD_LO]};            // [R05]
      no_read_while_write_region_start = `V0_NO_READ_WHILE_WRITE_REGION_START;                                      // [R03]
    end
  end

  // boot section start from the fuse pair
  always_comb begin
    case ({boot_size_hi_in, boot_size_lo_in})
      2'b11:   boot_start_d = large_variant_in ? `V1_BOOT_11 : `V0_BOOT_11; // [R01] [R02]
      2'b10:   boot_start_d = large_variant_in ? `V1_BOOT_10 : `V0_BOOT_10; // [R01] [R02]
      2'b01:   boot_start_d = large_variant_in ? `V1_BOOT_01 : `V0_BOOT_01; // [R01] [R02]
      default: boot_start_d = large_variant_in ? `V1_BOOT_00 : `V0_BOOT_00; // [R01] [R02]
    endcase
  end

  // command sequencer; a late store is dropped so stray writes cannot program
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      // idle with nothing armed
      state_q <= ST_IDLE;
      op_q    <= OP_FILL;
      ctl_q   <= 8'h00;
      win_q   <= 3'h0;
      timer_q <= 24'h000000;
    end else if (ce_in) begin
      case (state_q)
        ST_IDLE: begin
          // only a write with enable set arms the sequencer
          if (ctl_write_in && ctl_data_in[`CTL_ENABLE_BIT]) begin
            ctl_q   <= ctl_data_in;
            win_q   <= `ARM_WINDOW;
            state_q <= ST_ARMED;
            // priority: erase, then write, then re-enable, else fill
            if (ctl_data_in[`CTL_ERASE_BIT])
              op_q <= OP_ERASE;
            else if (ctl_data_in[`CTL_WRITE_BIT])
              op_q <= OP_WRITE;
            else if (ctl_data_in[`CTL_REENABLE_BIT])
              op_q <= OP_REEN;
            else
              op_q <= OP_FILL;
          end
        end
        ST_ARMED: begin
          // timed operations start the timer, fill and re-enable finish now
          if (spm_exec_in) begin
            if (op_q == OP_ERASE || op_q == OP_WRITE) begin
              timer_q <= PROG_CYC;                                       // [R21]
              state_q <= ST_BUSY;
            end else begin
              ctl_q   <= 8'h00;
              state_q <= ST_IDLE;
            end
          end else if (win_q == 3'h1) begin
            // window ran out: command discarded, enable drops
            ctl_q   <= 8'h00;                                            // [R22]
            state_q <= ST_IDLE;
          end else begin
            win_q <= win_q - 3'h1;
          end
        end
        ST_BUSY: begin
          // writes here are ignored and enable stays visible
          if (timer_q == 24'h000001) begin                               // [R23]
            // last count: enable falls so polling software sees completion
            ctl_q   <= 8'h00;
            state_q <= ST_IDLE;
          end else begin
            timer_q <= timer_q - 24'h000001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // buffer fill from r1:r0 at the word field
  always_ff @(posedge clk_in) begin
    // no reset: software fills every word it writes, so a reset tree buys nothing
    if (ce_in && state_q == ST_ARMED && spm_exec_in && op_q == OP_FILL)
      page_buf[word_sel] <= r1r0_in;                                     // [R18] [R07]
  end

  // array request; page field only for erase and write
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      flash_req_out   <= '0;
      flash_start_out <= 1'b0;
      buf_word_out    <= 16'h0000;
    end else if (ce_in) begin
      // start is a single-cycle pulse
      flash_start_out <= 1'b0;
      // array read port, one cycle behind the index
      buf_word_out    <= page_buf[buf_rd_index_in];
      if (state_q == ST_ARMED && spm_exec_in && (op_q == OP_ERASE || op_q == OP_WRITE)) begin
        flash_req_out.erase <= (op_q == OP_ERASE);                       // [R17]
        flash_req_out.write <= (op_q == OP_WRITE);                       // [R19]
        // both variants carry seven page bits, the top one included
        flash_req_out.page  <= page_sel;                                 // [R05] [R06] [R07]
        flash_start_out     <= 1'b1;
      end
    end
  end

  // readable-section busy: set on erase/write, cleared only by re-enable
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      busy_q <= 1'b0;
    end else if (ce_in && state_q == ST_ARMED && spm_exec_in) begin
      // re-enable never meets erase or write in one cycle, so order is moot
      if (op_q == OP_ERASE || op_q == OP_WRITE)
        busy_q <= 1'b1;                                                  // [R15]
      else if (op_q == OP_REEN)
        busy_q <= 1'b0;                                                  // [R16]
    end
  end

  // registered status outputs
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctl_read_out              <= 8'h00;
      readable_section_busy_out <= 1'b0;
      // fetches allowed out of reset
      fetch_allowed_out         <= 1'b1;
      boot_start_out            <= 13'h0000;
      app_end_out               <= 13'h0000;
      byte_select_out           <= 1'b0;
    end else if (ce_in) begin
      // command bits read back, bit 6 shows the busy flag
      ctl_read_out              <= {ctl_q[7], busy_q, ctl_q[5:0]};        // [R13]
      readable_section_busy_out <= busy_q;                               // [R15]
      // fetch gate applies only while the array runs
      fetch_allowed_out         <= (state_q != ST_BUSY) || (fetch_addr_in >= no_read_while_write_region_start); // [R12]
      boot_start_out            <= boot_start_d;
      app_end_out               <= boot_start_d - 13'h0001;
      byte_select_out           <= z_pointer_in[0];                      // [R09]
    end
  end

endmodule

`default_nettype wire

// ### tb/flash_spm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module flash_spm_monitor
  import flash_spm_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rstn_in,
  // core side
  input wire logic        large_variant_in,
  input wire logic        ctl_write_in,
  input wire logic [7:0]  ctl_data_in,
  input wire logic        spm_exec_in,
  input wire logic [15:0] z_pointer_in,
  input wire logic [12:0] fetch_addr_in,
  // status and array side
  input wire logic [7:0]  ctl_read_out,
  input wire logic        readable_section_busy_out,
  input wire logic        fetch_allowed_out,
  input wire logic [12:0] boot_start_out,
  input wire logic [12:0] app_end_out,
  input wire logic        byte_select_out,
  input wire flash_req_t  flash_req_out,
  input wire logic        flash_start_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // protected region start, the only place fetches may hit during a run
  logic [12:0] no_read_while_write_region;
  assign no_read_while_write_region = large_variant_in ? 13'h1c00 : 13'h0c00;
  // cycles since an erase/write started; enable must not fall before 3.7 ms
  logic [19:0] run_cnt;
  always_ff @(posedge clk_in) begin
    if (!rstn_in)
      run_cnt <= 20'h00000;
    else if (flash_start_out)
      run_cnt <= 20'h00001;
    else if (run_cnt != 20'h00000 && ctl_read_out[0])
      run_cnt <= run_cnt + 20'h00001;
    else
      run_cnt <= 20'h00000;
  end
  // address, pulse and refusal relations
  a_app_below: assert property (boot_start_out != 13'h0 |-> app_end_out == boot_start_out - 13'h1)
    else $error("app end not below boot start");
  a_byte_sel: assert property ($past(rstn_in) |-> byte_select_out == $past(z_pointer_in[0]))
    else $error("byte select off pointer bit 0");
  a_page_pick: assert property (flash_start_out |-> flash_req_out.page ==
    (large_variant_in ? $past(z_pointer_in[13:7]) : $past(z_pointer_in[12:6]))) else $error("wrong page");
  a_busy_follow: assert property (flash_start_out |=> readable_section_busy_out)
    else $error("busy not set after start");
  a_start_once: assert property (flash_start_out |=> !flash_start_out)
    else $error("start longer than one cycle");
  a_fetch_block: assert property (!fetch_allowed_out |-> $past(fetch_addr_in) < no_read_while_write_region)
    else $error("protected fetch blocked");
  a_late_drop: assert property ((ctl_write_in && ctl_data_in == 8'h01 && !ctl_read_out[0])
    ##1 !spm_exec_in [*4] |-> ##[1:2] !ctl_read_out[0]) else $error("late store kept command");
  a_refuse_busy: assert property (readable_section_busy_out && ctl_read_out[0] |-> !flash_start_out)
    else $error("command taken while busy");
  a_prog_min: assert property (run_cnt != 20'h00000 && run_cnt < 20'he1d48 |-> ctl_read_out[0])
    else $error("operation ended before minimum time");
  c_erase: cover property (flash_start_out && flash_req_out.erase);
  c_write: cover property (flash_start_out && flash_req_out.write);
  c_gate: cover property (!fetch_allowed_out);
endmodule
bind flash_self_program_control flash_spm_monitor mon_u (.clk_in, .rstn_in, .large_variant_in, .ctl_write_in,
  .ctl_data_in, .spm_exec_in, .z_pointer_in, .fetch_addr_in, .ctl_read_out, .readable_section_busy_out,
  .fetch_allowed_out, .boot_start_out, .app_end_out, .byte_select_out, .flash_req_out, .flash_start_out);
`default_nettype wire

// ### tb/flash_self_program_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_tb;
  import flash_spm_pkg::*;
  logic        clk_in, rstn_in, ce_in, lg, cw, sx, eep, bsy, fok, bsel, st;
  logic [1:0]  bz;
  logic [7:0]  cd, cr;
  logic [15:0] zp, wd, bw;
  logic [12:0] fa, bs, ae;
  logic [5:0]  ix;
  flash_req_t  rq;
  int          failures, n_tests, seed, cyc;
  // device under test
  flash_self_program_control dut_u (.clk_in, .rstn_in, .ce_in, .large_variant_in(lg), .boot_size_hi_in(bz[1]),
    .boot_size_lo_in(bz[0]), .ctl_write_in(cw), .ctl_data_in(cd), .spm_exec_in(sx), .z_pointer_in(zp),
    .r1r0_in(wd), .fetch_addr_in(fa), .eeprom_write_pending_in(eep), .ctl_read_out(cr),
    .readable_section_busy_out(bsy), .fetch_allowed_out(fok), .boot_start_out(bs), .app_end_out(ae),
    .byte_select_out(bsel), .flash_req_out(rq), .flash_start_out(st), .buf_word_out(bw), .buf_rd_index_in(ix));
  // 4 ns clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // hang guard, whole run needs well under this
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end
  // boot start from size code: top of flash minus boot size
  function automatic logic [12:0] bexp(input logic l, input logic [1:0] c);
    bexp = (l ? 13'h0000 : 13'h1000) - (13'h0080 << (2'h3 - c));
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rst;
    rstn_in = 1'b0;
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
  endtask
  // control write then store after gap cycles; eeprom never pending
  task automatic cmd(input logic [7:0] d, input int gap);
    for (int k = 0; k < 8 && (cr[0] || eep); k++) @(negedge clk_in);
    cd = d;
    cw = 1'b1;
    @(negedge clk_in);
    cw = 1'b0;
    repeat (gap - 1) @(negedge clk_in);
    sx = 1'b1;
    @(negedge clk_in);
    sx = 1'b0;
  endtask
  // gap 5 reuses the last slot so a dropped fill must leave it alone
  task automatic fill(input int gap);
    logic [15:0] old;
    if (gap < 5) zp = 16'($random(seed)) & 16'hfffe;
    ix = lg ? zp[6:1] : {1'b0, zp[5:1]};
    wd = 16'($random(seed));
    @(negedge clk_in);
    old = bw;
    cmd(8'h01, gap);
    repeat (2) @(negedge clk_in);
    chk(bw, gap < 5 ? wd : old);
  endtask
  task automatic gate(input logic [12:0] b);
    fa = b - 13'h1;
    repeat (2) @(negedge clk_in);
    chk(16'(fok), 16'h0);
    fa = b;
    repeat (2) @(negedge clk_in);
    chk(16'(fok), 16'h1);
  endtask
  // main sequence
  initial begin
    seed = 73348;
    {rstn_in, lg, bz, cw, cd, sx, zp, wd, fa, eep, ix} = '0;
    ce_in = 1'b1;
    rst();
    for (int c = 0; c < 8; c++) begin
      {lg, bz} = c[2:0];
      repeat (2) @(negedge clk_in);
      chk(16'(bs), 16'(bexp(lg, bz)));
      chk(16'(ae), 16'(bexp(lg, bz) - 13'h1));
    end
    ce_in = 1'b0; // outputs must hold while frozen
    {lg, bz} = 3'h3;
    repeat (2) @(negedge clk_in);
    chk(16'(bs), 16'(bexp(1'b1, 2'h3)));
    ce_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(16'(bs), 16'(bexp(1'b0, 2'h3)));
    cmd(8'h11, 1);
    @(negedge clk_in);
    chk({st, bsy, cr}, 16'h0000);
    $display("boot map done");
    for (int v = 0; v < 2; v++) begin
      lg = v[0];
      for (int i = 0; i < 12; i++) fill(1 + i % 4);
      fill(5);
    end
    $display("fill done");
    zp = 16'($random(seed)) & 16'hfffe;
    cmd(8'h03, 2);
    chk({st, rq.erase, 7'h0, rq.page}, {2'b11, 7'h0, zp[13:7]});
    @(negedge clk_in);
    chk({bsy, cr[0]}, 16'h3);
    gate(13'h1c00);
    cmd(8'h05, 1);
    @(negedge clk_in);
    chk({st, cr[0]}, 16'h1);
    rst();
    $display("erase done");
    lg = 1'b0;
    zp = 16'($random(seed)) & 16'hffc0;
    cmd(8'h05, 3);
    chk({st, rq.write, 7'h0, rq.page}, {2'b11, 7'h0, zp[12:6]});
    gate(13'h0c00);
    rst();
    $display("page write done");
    wrap_up();
  end
endmodule
`default_nettype wire
